// >>> core/dpcb_bank.sv
// Drive parameter bank: parameter port, torque direction, speed limit,
// error latching, alarm routing, encoder scaling, station address and baud.
// Assumes all inputs but resetn synchronous to clk; special, inertia, station and baud parameters written over par_* port.
`timescale 1ns/1ns
module dpcb_bank #(
  parameter int MS_CYCLES = dpcb_pkg::MS_CYCLES,
  parameter int HOLD_MS   = dpcb_pkg::HOLD_MS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [15:0] par_wdata,
  output logic             par_resp_q,
  output logic             par_err_q,
  output logic      [15:0] par_rdata_q,
  input  wire logic        torque_pass_input,
  input  wire logic        torque_negate_input,
  input  wire logic        torque_src_sel_lo,
  input  wire logic        torque_src_sel_hi,
  input  wire logic [15:0] torque_src0,
  input  wire logic [15:0] torque_src1,
  input  wire logic [15:0] torque_src2,
  input  wire logic [15:0] torque_src3,
  output logic      [15:0] torque_out_q,
  input  wire logic [7:0]  limit_mode_param,
  input  wire logic        speed_limit_input,
  input  wire logic        speed_sel_lo,
  input  wire logic        speed_sel_hi,
  input  wire logic [15:0] speed_lim0,
  input  wire logic [15:0] speed_lim1,
  input  wire logic [15:0] speed_lim2,
  input  wire logic [15:0] speed_lim3,
  input  wire logic [15:0] accel_time_param,
  input  wire logic [15:0] decel_time_param,
  input  wire logic [15:0] scurve_time_param,
  output logic             speed_limit_active_q,
  output logic      [15:0] speed_limit_cmd,
  input  wire logic        low_volt_event,
  input  wire logic        low_volt_clear,
  output logic             low_volt_err_q,
  input  wire logic        motor_temp_warn,
  output logic             temp_warn_disp_q,
  input  wire logic        drive_alarm_three,
  output logic             do_warn_q,
  output logic             do_alt_q,
  output logic      [7:0]  do_func_q,
  input  wire logic [15:0] encoder_out_pulses,
  output logic      [17:0] enc_host_count_q,
  input  wire logic        semi_auto,
  input  wire logic [15:0] inertia_est,
  output logic             inertia_done_q,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_addr,
  output logic             req_accept,
  output logic      [7:0]  station_addr_q,
  output logic      [16:0] port0_baud_q,
  output logic      [16:0] port1_baud_q
);

  initial if (MS_CYCLES < 2 || HOLD_MS < 1 || HOLD_MS > 65535) $error("dpcb_bank: bad parameter.");

  //////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parameter registers.
  logic [15:0] special_q, special_d;
  logic [15:0] inertia_thr_q, inertia_thr_d;
  logic [15:0] station_q, station_d;
  logic [15:0] baud_q, baud_d;
  logic        resp_d, err_d;
  logic [15:0] rdata_d;
  logic        hit;
  logic        ok;

  always_comb
  begin
    special_d     = special_q;
    inertia_thr_d = inertia_thr_q;
    station_d     = station_q;
    baud_d        = baud_q;
    rdata_d       = 16'h0;
    hit           = 1'b1;
    ok            = 1'b1;
    unique case (par_addr)
      dpcb_pkg::ADDR_SPECIAL: rdata_d = special_q;
      dpcb_pkg::ADDR_INERTIA:
      begin
        rdata_d = inertia_thr_q;
        ok      = par_wdata <= dpcb_pkg::INERTIA_MAX;
      end
      dpcb_pkg::ADDR_STATION:
      begin
        rdata_d = station_q;
        ok      = par_wdata >= dpcb_pkg::STATION_MIN && par_wdata <= dpcb_pkg::STATION_MAX;
      end
      dpcb_pkg::ADDR_BAUD:
      begin
        rdata_d = baud_q;
        ok      = par_wdata[15:8] == 8'h0 && par_wdata[7:4] <= dpcb_pkg::BAUD_DIG_MAX
                  && par_wdata[3:0] <= dpcb_pkg::BAUD_DIG_MAX;
      end
      default: hit = 1'b0;
    endcase
    if (par_wr && hit && ok)
    begin
      unique case (par_addr)
        dpcb_pkg::ADDR_SPECIAL: special_d = par_wdata & dpcb_pkg::SPECIAL_MASK;
        dpcb_pkg::ADDR_INERTIA: inertia_thr_d = par_wdata;
        dpcb_pkg::ADDR_STATION: station_d = par_wdata;
        default:                baud_d = par_wdata;
      endcase
    end
    resp_d = par_wr || par_rd;
    err_d  = (par_wr || par_rd) && (!hit || (par_wr && !ok));
    if (!par_rd)
      rdata_d = 16'h0;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      special_q     <= dpcb_pkg::RST_SPECIAL;
      inertia_thr_q <= dpcb_pkg::RST_INERTIA;
      station_q     <= dpcb_pkg::RST_STATION;
      baud_q        <= dpcb_pkg::RST_BAUD;
      par_resp_q    <= 1'b0;
      par_err_q     <= 1'b0;
      par_rdata_q   <= 16'h0;
    end
    else
    begin
      special_q     <= special_d;
      inertia_thr_q <= inertia_thr_d;
      station_q     <= station_d;
      baud_q        <= baud_d;
      par_resp_q    <= resp_d;
      par_err_q     <= err_d;
      par_rdata_q   <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond enable.
  logic [$clog2(MS_CYCLES)-1:0] div_q, div_d;
  logic                         ms_tick;

  always_comb
  begin
    ms_tick = div_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);
    div_d   = ms_tick ? '0 : div_q + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Torque, speed limit, errors, alarm and encoder outputs.
  logic [15:0] sel_cmd;
  logic [15:0] torque_d;
  logic        spd_act_d;
  logic        lv_d;
  logic        temp_d;
  logic        warn_d, alt_d;
  logic [7:0]  func_d;
  logic [17:0] enc_d;
  logic [15:0] spd_target;

  always_comb
  begin
    unique case ({torque_src_sel_hi, torque_src_sel_lo})
      2'b00:   sel_cmd = torque_src0;
      2'b01:   sel_cmd = torque_src1;
      2'b10:   sel_cmd = torque_src2;
      default: sel_cmd = torque_src3;
    endcase
    if (torque_pass_input && !torque_negate_input)
      torque_d = sel_cmd;
    else if (!torque_pass_input && torque_negate_input)
      torque_d = (sel_cmd == 16'h8000) ? 16'h7fff : 16'h0 - sel_cmd;
    else
      torque_d = 16'h0;
    unique case ({speed_sel_hi, speed_sel_lo})
      2'b00:   spd_target = speed_lim0;
      2'b01:   spd_target = speed_lim1;
      2'b10:   spd_target = speed_lim2;
      default: spd_target = speed_lim3;
    endcase
    spd_act_d = limit_mode_param == dpcb_pkg::LIMIT_ALWAYS || speed_limit_input;
    lv_d = low_volt_err_q;
    if (special_q[dpcb_pkg::BIT_LV_AUTO])
      lv_d = low_volt_event;
    else if (low_volt_event)
      lv_d = 1'b1;
    else if (low_volt_clear)
      lv_d = 1'b0;
    temp_d = motor_temp_warn && !special_q[dpcb_pkg::BIT_TEMP_HIDE];
    alt_d  = drive_alarm_three && special_q[dpcb_pkg::BIT_ALARM_ALT];
    warn_d = drive_alarm_three && !special_q[dpcb_pkg::BIT_ALARM_ALT];
    func_d = alt_d ? dpcb_pkg::DO_FUNC_ALT : warn_d ? dpcb_pkg::DO_FUNC_WARN : dpcb_pkg::DO_FUNC_NONE;
    if (special_q[dpcb_pkg::BIT_ENC_QUAD])
      enc_d = {2'b00, encoder_out_pulses};
    else
      enc_d = {encoder_out_pulses, 2'b00};
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      div_q                <= '0;
      torque_out_q         <= 16'h0;
      speed_limit_active_q <= 1'b0;
      low_volt_err_q       <= 1'b0;
      temp_warn_disp_q     <= 1'b0;
      do_warn_q            <= 1'b0;
      do_alt_q             <= 1'b0;
      do_func_q            <= dpcb_pkg::DO_FUNC_NONE;
      enc_host_count_q     <= 18'h0;
    end
    else
    begin
      div_q                <= div_d;
      torque_out_q         <= torque_d;
      speed_limit_active_q <= spd_act_d;
      low_volt_err_q       <= lv_d;
      temp_warn_disp_q     <= temp_d;
      do_warn_q            <= warn_d;
      do_alt_q             <= alt_d;
      do_func_q            <= func_d;
      enc_host_count_q     <= enc_d;
    end
  end

  dpcb_ramp #(
    .W (16)
  ) u_ramp (
    .clk       (clk),
    .rst_n     (rst_n_q),
    .ms_tick   (ms_tick),
    .enable    (special_q[dpcb_pkg::BIT_RAMP_EN]),
    .target    (spd_target),
    .accel_ms  (accel_time_param),
    .decel_ms  (decel_time_param),
    .smooth_ms (scurve_time_param),
    .value_q   (speed_limit_cmd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Inertia estimate stability, station address and baud rates.
  logic [15:0] hold_q, hold_d;
  logic        done_d;

  always_comb
  begin
    hold_d = hold_q;
    if (!(semi_auto && inertia_est < inertia_thr_q))
      hold_d = 16'h0;
    else if (ms_tick && hold_q != 16'(HOLD_MS))
      hold_d = hold_q + 16'h1;
    done_d = hold_d == 16'(HOLD_MS);
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      hold_q         <= 16'h0;
      inertia_done_q <= 1'b0;
      station_addr_q <= dpcb_pkg::RST_STATION[7:0];
      port0_baud_q   <= 17'h0;
      port1_baud_q   <= 17'h0;
    end
    else
    begin
      hold_q         <= hold_d;
      inertia_done_q <= done_d;
      station_addr_q <= station_q[7:0];
      port0_baud_q   <= dpcb_pkg::baud_rate(baud_q[3:0]);
      port1_baud_q   <= dpcb_pkg::baud_rate(baud_q[7:4]);
    end
  end

  assign req_accept = req_valid && (req_addr == dpcb_pkg::ADDR_BROADCAST || req_addr == station_q[7:0]);

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  torque_pass_a: assert property ((torque_pass_input && !torque_negate_input) |=> torque_out_q == $past(sel_cmd))
    else $error("Torque not passed through.");
  torque_zero_a: assert property ((torque_pass_input == torque_negate_input) |=> torque_out_q == 16'h0)
    else $error("Torque not zero.");
  torque_neg_a: assert property ((!torque_pass_input && torque_negate_input && sel_cmd != 16'h8000)
    |=> torque_out_q + $past(sel_cmd) == 16'h0)
    else $error("Torque not negated.");
  torque_src_a: assert property ((torque_pass_input && !torque_negate_input && !torque_src_sel_hi && torque_src_sel_lo)
    |=> torque_out_q == $past(torque_src1))
    else $error("Wrong torque source.");
  spd_always_a: assert property ((limit_mode_param == dpcb_pkg::LIMIT_ALWAYS) |=> speed_limit_active_q)
    else $error("Speed limit not held active.");
  lv_latch_a: assert property ((low_volt_err_q && !special_q[dpcb_pkg::BIT_LV_AUTO] && !low_volt_clear)
    |=> low_volt_err_q)
    else $error("Low-voltage error dropped while latched.");
  lv_auto_a: assert property ((special_q[dpcb_pkg::BIT_LV_AUTO] && !low_volt_event)[*2] |-> !low_volt_err_q)
    else $error("Low-voltage error not cleared automatically.");
  temp_hide_a: assert property ((motor_temp_warn && $stable(special_q))
    |=> temp_warn_disp_q == !$past(special_q[dpcb_pkg::BIT_TEMP_HIDE]))
    else $error("Temperature warning display wrong.");
  alarm_route_a: assert property ((drive_alarm_three && $stable(special_q)) |=> do_func_q ==
    ($past(special_q[dpcb_pkg::BIT_ALARM_ALT]) ? dpcb_pkg::DO_FUNC_ALT : dpcb_pkg::DO_FUNC_WARN))
    else $error("Alarm routed to wrong output.");
  enc_scale_a: assert property ($stable(special_q) |=> enc_host_count_q ==
    ($past(special_q[dpcb_pkg::BIT_ENC_QUAD]) ?
    {2'b00, $past(encoder_out_pulses)} : {$past(encoder_out_pulses), 2'b00}))
    else $error("Encoder scaling wrong.");
  reserved_a: assert property ((special_q & ~dpcb_pkg::SPECIAL_MASK) == 16'h0)
    else $error("Reserved special bit set.");
  station_rng_a: assert property (station_q >= dpcb_pkg::STATION_MIN && station_q <= dpcb_pkg::STATION_MAX)
    else $error("Station address out of range.");
  baud_rng_a: assert property (baud_q[15:8] == 8'h0 && baud_q[7:4] <= dpcb_pkg::BAUD_DIG_MAX)
    else $error("Baud selection out of range.");
  reject_a: assert property ((par_wr && par_addr == dpcb_pkg::ADDR_STATION && par_wdata == 16'h0)
    |=> station_q == $past(station_q) && par_err_q)
    else $error("Out-of-range write not rejected.");
  broadcast_a: assert property ((req_valid && req_addr == dpcb_pkg::ADDR_BROADCAST) |-> req_accept)
    else $error("Broadcast request refused.");
  inertia_done_a: assert property (inertia_done_q |-> $past(semi_auto && inertia_est < inertia_thr_q))
    else $error("Inertia done without stable estimate.");

  neg_c: cover property (!torque_pass_input && torque_negate_input ##1 torque_out_q != 16'h0);
  lv_c: cover property (low_volt_err_q && low_volt_clear ##1 !low_volt_err_q);
  wr_c: cover property (par_wr && par_addr == dpcb_pkg::ADDR_BAUD ##1 !par_err_q);
  done_c: cover property ($rose(inertia_done_q));

endmodule // dpcb_bank

// >>> core/dpcb_pkg.sv
// Constants shared by the drive parameter bank and its test bench.
// Assumes a 10 MHz system clock and a 16-bit parameter access port.
package dpcb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Parameter addresses.
  localparam logic [15:0] ADDR_SPECIAL = 16'h0284;
  localparam logic [15:0] ADDR_INERTIA = 16'h0286;
  localparam logic [15:0] ADDR_STATION = 16'h0300;
  localparam logic [15:0] ADDR_BAUD    = 16'h0302;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and ranges.
  localparam logic [15:0] RST_SPECIAL  = 16'h0000;
  localparam logic [15:0] RST_INERTIA  = 16'h000f;
  localparam logic [15:0] RST_STATION  = 16'h007f;
  localparam logic [15:0] RST_BAUD     = 16'h0033;
  localparam logic [15:0] INERTIA_MAX  = 16'h07d0;
  localparam logic [15:0] STATION_MIN  = 16'h0001;
  localparam logic [15:0] STATION_MAX  = 16'h007f;
  localparam logic [3:0]  BAUD_DIG_MAX = 4'h5;
  localparam logic [15:0] SPECIAL_MASK = 16'h8285;

  //////////////////////////////////////////////////////////////////////////////
  // Special-function bit positions.
  localparam int BIT_RAMP_EN   = 0;
  localparam int BIT_LV_AUTO   = 2;
  localparam int BIT_TEMP_HIDE = 7;
  localparam int BIT_ALARM_ALT = 9;
  localparam int BIT_ENC_QUAD  = 15;

  //////////////////////////////////////////////////////////////////////////////
  // Codes.
  localparam logic [7:0]  ADDR_BROADCAST = 8'hff;
  localparam logic [7:0]  LIMIT_ALWAYS   = 8'h10;
  localparam logic [7:0]  DO_FUNC_WARN   = 8'h11;
  localparam logic [7:0]  DO_FUNC_ALT    = 8'h07;
  localparam logic [7:0]  DO_FUNC_NONE   = 8'h00;
  localparam int          ENC_QUAD_SHIFT = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int HOLD_MS       = 100;

  // Baud rate in bit/s for a selection digit.
  function automatic logic [16:0] baud_rate(input logic [3:0] code);
    logic [16:0] r;
    r = 17'h0;
    unique case (code)
      4'h0:    r = 17'h012c0;
      4'h1:    r = 17'h02580;
      4'h2:    r = 17'h04b00;
      4'h3:    r = 17'h09600;
      4'h4:    r = 17'h0e100;
      4'h5:    r = 17'h1c200;
      default: r = 17'h0;
    endcase
    return r;
  endfunction

endpackage

// >>> core/dpcb_ramp.sv
// Speed-limit ramp: walks its output towards a target one step per interval.
// Assumes a one-cycle millisecond enable pulse from the parent.
`timescale 1ns/1ns
module dpcb_ramp #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ms_tick,
  input  wire logic         enable,
  input  wire logic [W-1:0] target,
  input  wire logic [15:0]  accel_ms,
  input  wire logic [15:0]  decel_ms,
  input  wire logic [15:0]  smooth_ms,
  output logic      [W-1:0] value_q
);

  initial if (W < 2) $error("dpcb_ramp: W too small.");

  logic [16:0]  cnt_q;
  logic [16:0]  cnt_d;
  logic [W-1:0] value_d;
  logic [16:0]  period;
  logic         up;

  //////////////////////////////////////////////////////////////////////////////
  // Step interval is the accel or decel time plus the smoothing time.
  always_comb
  begin
    up      = target > value_q;
    period  = (up ? {1'b0, accel_ms} : {1'b0, decel_ms}) + {1'b0, smooth_ms};
    cnt_d   = cnt_q;
    value_d = value_q;
    if (!enable)
    begin
      value_d = target;
      cnt_d   = 17'h0;
    end
    else if (value_q == target)
      cnt_d = 17'h0;
    else if (ms_tick)
    begin
      if (cnt_d + 17'h1 >= period)
      begin
        cnt_d   = 17'h0;
        value_d = up ? value_q + W'(1) : value_q - W'(1);
      end
      else
        cnt_d = cnt_q + 17'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= 17'h0;
      value_q <= '0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      value_q <= value_d;
    end
  end

endmodule // dpcb_ramp

// >>> tb/dpcb_host.sv
// Host controller model: issues parameter reads and writes on the port.
// Assumes the bank answers on the same edge that takes a strobe.
`timescale 1ns/1ns
module dpcb_host (
  input  wire logic        clk,
  output logic             par_wr,
  output logic             par_rd,
  output logic      [15:0] par_addr,
  output logic      [15:0] par_wdata,
  input  wire logic        par_resp_q,
  input  wire logic        par_err_q,
  input  wire logic [15:0] par_rdata_q
);
  initial
  begin
    par_wr    = 1'b0;
    par_rd    = 1'b0;
    par_addr  = 16'h5a5a;
    par_wdata = 16'ha5a5;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One transfer; released strobes drop to 0, address and data carry the inverse of their last value.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic e, output logic [15:0] q);
    @(posedge clk);
    #5;
    par_wr    = w;
    par_rd    = ~w;
    par_addr  = a;
    par_wdata = d;
    @(posedge clk);
    #5;
    e         = par_resp_q ? par_err_q : 1'bx;
    q         = par_resp_q ? par_rdata_q : 16'hxxxx;
    par_wr    = 1'b0;
    par_rd    = 1'b0;
    par_addr  = ~a;
    par_wdata = ~d;
  endtask
endmodule // dpcb_host

// >>> tb/dpcb_bank_test.sv
// Self-checking bench of the drive parameter bank.
// Assumes a 10 MHz clock and shortened millisecond counts.
`timescale 1ns/1ns
module dpcb_bank_test;
  logic clk = 1'b0, resetn = 1'b1;
  logic wr, rd, resp, perr, tp = 0, tn = 0, sl = 0, sh = 0, sli = 0, ssl = 0, ssh = 0;
  logic [15:0] pa, pd, prd, s0 = 0, s1 = 0, s2 = 0, s3 = 0, tq, slc, enc = 0, est = 16'h0100;
  logic [7:0] lm = 0, ra = 0, sta, dof;
  logic lve = 0, lvc = 0, lverr, mtw = 0, twd, al = 0, dw, dal, semi = 0, idone, rv = 0, racc, sla;
  logic [17:0] ehc;
  logic [16:0] b0, b1;
  logic [31:0] seed = 32'd94;
  logic e;
  logic [15:0] q;
  int err_total = 0, n_compared = 0;

  always #50 clk = ~clk;

  dpcb_host dpcb_host_inst (.clk(clk), .par_wr(wr), .par_rd(rd), .par_addr(pa), .par_wdata(pd),
    .par_resp_q(resp), .par_err_q(perr), .par_rdata_q(prd));

  dpcb_bank #(.MS_CYCLES(4), .HOLD_MS(3)) dpcb_bank_inst (.clk(clk), .resetn(resetn), .par_wr(wr),
    .par_rd(rd), .par_addr(pa), .par_wdata(pd), .par_resp_q(resp), .par_err_q(perr),
    .par_rdata_q(prd), .torque_pass_input(tp), .torque_negate_input(tn), .torque_src_sel_lo(sl),
    .torque_src_sel_hi(sh), .torque_src0(s0), .torque_src1(s1), .torque_src2(s2),
    .torque_src3(s3), .torque_out_q(tq), .limit_mode_param(lm), .speed_limit_input(sli),
    .speed_sel_lo(ssl), .speed_sel_hi(ssh), .speed_lim0(s0), .speed_lim1(s1), .speed_lim2(s2),
    .speed_lim3(s3), .accel_time_param(16'h0001), .decel_time_param(16'h0001),
    .scurve_time_param(16'h0000), .speed_limit_active_q(sla), .speed_limit_cmd(slc),
    .low_volt_event(lve), .low_volt_clear(lvc), .low_volt_err_q(lverr), .motor_temp_warn(mtw),
    .temp_warn_disp_q(twd), .drive_alarm_three(al), .do_warn_q(dw), .do_alt_q(dal),
    .do_func_q(dof), .encoder_out_pulses(enc), .enc_host_count_q(ehc), .semi_auto(semi),
    .inertia_est(est), .inertia_done_q(idone), .req_valid(rv), .req_addr(ra),
    .req_accept(racc), .station_addr_q(sta), .port0_baud_q(b0), .port1_baud_q(b1));

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [16:0] rate(input int c);
    case (c)
      0:       return 17'h012c0;
      1:       return 17'h02580;
      2:       return 17'h04b00;
      3:       return 17'h09600;
      4:       return 17'h0e100;
      default: return 17'h1c200;
    endcase
  endfunction
  function automatic logic [15:0] exp_tq(input logic [15:0] v);
    if (tp == tn)
      return 16'h0000;
    if (tp)
      return v;
    return (v == 16'h8000) ? 16'h7fff : -v;
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input logic [17:0] g, input logic [17:0] x);
    n_compared++;
    if (g !== x)
    begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w, input logic x);
    dpcb_host_inst.xfer(w, a, d, e, q);
    chk(e, x);
  endtask
  task automatic close_out();
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #2000000;
    err_total++;
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    #5;
    resetn = 1'b0;
    tick(20);
    resetn = 1'b1;
    tick(4);
    chk(b0, rate(3));
    acc(dpcb_pkg::ADDR_INERTIA, 0, 0, 0); chk(q, 16'h000f);
    acc(dpcb_pkg::ADDR_STATION, 0, 0, 0); chk(q, 16'h007f);
    acc(dpcb_pkg::ADDR_BAUD, 0, 0, 0); chk(q, 16'h0033);
    acc(dpcb_pkg::ADDR_SPECIAL, 0, 0, 0); chk(q, 16'h0000);
    acc(16'h0288, 0, 0, 1);
    acc(dpcb_pkg::ADDR_SPECIAL, 16'hffff, 1, 0);
    acc(dpcb_pkg::ADDR_SPECIAL, 0, 0, 0); chk(q, 16'h8285);
    acc(dpcb_pkg::ADDR_STATION, 16'h0001, 1, 0);
    acc(dpcb_pkg::ADDR_STATION, 16'h0012, 1, 0);
    acc(dpcb_pkg::ADDR_STATION, 16'h0000, 1, 1);
    acc(dpcb_pkg::ADDR_STATION, 16'h0080, 1, 1);
    acc(dpcb_pkg::ADDR_STATION, 16'h00ff, 1, 1);
    acc(dpcb_pkg::ADDR_STATION, 0, 0, 0); chk(q, 16'h0012);
    chk(sta, 8'h12);
    rv = 1;
    ra = 8'h12;
    tick();
    chk(racc, 1);
    ra = 8'hff;
    tick();
    chk(racc, 1);
    ra = 8'h13;
    tick();
    chk(racc, 0);
    rv = 0;
    for (int c = 0; c < 6; c++)
    begin
      acc(dpcb_pkg::ADDR_BAUD, 16'((5 - c) << 4 | c), 1, 0);
      tick(2);
      chk(b0, rate(c));
      chk(b1, rate(5 - c));
    end
    acc(dpcb_pkg::ADDR_BAUD, 16'h0056, 1, 1);
    acc(dpcb_pkg::ADDR_BAUD, 16'h0133, 1, 1);
    acc(dpcb_pkg::ADDR_BAUD, 0, 0, 0); chk(q, 16'h0005);
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      {tp, tn, sl, sh} = (i == 0) ? 4'h4 : seed[3:0];
      s0 = (i == 0) ? 16'h8000 : seed[31:16];
      s1 = seed[23:8];
      s2 = ~seed[15:0];
      s3 = seed[27:12];
      {ssh, ssl, sli, lm[4], mtw, al} = seed[9:4];
      enc = seed[25:10];
      tick();
      chk(tq, exp_tq(sh ? (sl ? s3 : s2) : (sl ? s1 : s0)));
      chk(sla, sli | lm[4]);
    end
    for (int m = 0; m < 2; m++)
    begin
      acc(dpcb_pkg::ADDR_SPECIAL, m ? 16'h8284 : 16'h0000, 1, 0);
      mtw = 1; al = 1; tick(2);
      chk(twd, !m);
      chk(dof, m ? 8'h07 : 8'h11);
      chk({dw, dal}, m ? 2'b01 : 2'b10);
      chk(ehc, m ? {2'b00, enc} : {enc, 2'b00});
      lve = 1; tick(2); lve = 0; tick(2);
      chk(lverr, !m);
      lve = 1;
      lvc = 1;
      tick();
      lve = 0;
      lvc = 0;
      tick();
      chk(lverr, !m);
      lvc = 1; tick(); lvc = 0; tick(2);
      chk(lverr, 0);
    end
    for (int k = 0; k < 4; k++)
    begin
      {ssh, ssl} = 2'(k);
      tick();
      chk(slc, ssh ? (ssl ? s3 : s2) : (ssl ? s1 : s0));
    end
    s0 = 16'h0010;
    {ssh, ssl} = 2'b00;
    acc(dpcb_pkg::ADDR_SPECIAL, 16'h0001, 1, 0);
    s0 = 16'h0014;
    tick(4);
    chk(slc, 16'h0011);
    tick(12);
    chk(slc, 16'h0014);
    s0 = 16'h0012;
    tick(4);
    chk(slc, 16'h0013);
    semi = 1;
    tick(20);
    chk(idone, 0);
    est = 16'h000e;
    tick(24);
    chk(idone, 1);
    acc(dpcb_pkg::ADDR_INERTIA, 16'h07d1, 1, 1);
    acc(dpcb_pkg::ADDR_INERTIA, 0, 0, 0);
    chk(q, 16'h000f);
    resetn = 1'b0;
    tick();
    resetn = 1'b1;
    tick(3);
    chk(sta, 8'h7f);
    chk(b0, rate(3));
    acc(dpcb_pkg::ADDR_BAUD, 0, 0, 0);
    chk(q, 16'h0033);
    close_out();
  end
endmodule // dpcb_bank_test
